// file: hdc_holdover.sv
/*
  holdover dac control: register bank, dac tracking, holdover state,
  dac source selection, trip detection and interrupt status.
  assumes analog comparators and the lock detector arrive as asynchronous
  pins, and a byte register port with read data one cycle after the strobe.
*/
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - the two-bit timeout field picks the activity threshold for input loss, codes 0..3 being 5, 25, 100, 200 MHz.
// - one enable bit switches signal-absence detection on or off, for mos-format inputs only.
// - with tracking enabled the dac follows the tuning voltage, updating only while the first loop is locked.
// - after reset the tracked code starts at 512.
// - tracking runs in either dac source mode, but only outside holdover, so software can monitor the tuning voltage.
// - setting force-holdover places the device in holdover and clearing it removes the forcing.
// - in holdover the dac takes the manual code when manual mode is selected, else the last tracked code.
// - the manual select bit resets to one; zero picks tracked, one picks the manual code.
// - the 10-bit manual code has its top two bits in the control register and its low eight in the next.
// - with tuning detection on, holdover is entered when the voltage falls to (N+1)/64 of supply.
// - with tuning detection on, holdover is entered when the voltage rises within (N+1)/64 of supply.
// - the exit mode bit leaves holdover on renewed input activity (0) or on first-loop lock (1).
// - when enabled, a falling lock detect raises a clock switch event and enters holdover; else no effect.
module hdc_holdover #(
  parameter int TRACK_DIV = 64
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register port
  input wire logic [hdc_pkg::ADDR_W-1:0] addr,
  input wire logic [hdc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [hdc_pkg::DATA_W-1:0] rdata,
  // asynchronous analog and loop status
  input wire logic first_loop_lock,
  input wire logic signal_absence,
  input wire logic tune_above_dac,
  // signal-absence detector setup
  output logic [1:0] signal_absence_timeout,
  output logic signal_absence_enable,
  // dac and holdover
  output logic [9:0] dac_code,
  output logic holdover_active,
  output logic clock_switch_event,
  // interrupt
  output logic irq
);

  generate
    if (TRACK_DIV < 2 || TRACK_DIV > 65536) begin : g_bad_div
      $error("TRACK_DIV out of range");
    end
  endgenerate

  localparam logic [15:0] DIV_LAST = 16'(TRACK_DIV - 1);

  // top six bits of a dac code for the trip compares
  function automatic logic [5:0] code_top(input logic [9:0] code);
    return code[9:4];
  endfunction

  hdc_pkg::hdc_ctrl_t ctrl;
  hdc_pkg::hdc_switch_t sw;
  hdc_pkg::hdc_state_t state;
  hdc_pkg::hdc_state_t next_state;
  logic [7:0] man_lo;
  logic [5:0] trip_lo;
  logic [5:0] trip_hi;
  logic [4:0] status;
  logic [4:0] mask;
  logic [9:0] trk;
  logic [9:0] next_trk;
  logic [9:0] next_dac;
  logic [15:0] div_cnt;
  logic lock_s;
  logic abs_s;
  logic above_s;
  logic lock_d;
  logic abs_d;
  logic [7:0] next_rdata;

  // pin inputs through three stages
  hdc_sync #(
    .WIDTH(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in({first_loop_lock, signal_absence, tune_above_dac}),
    .level({lock_s, abs_s, above_s})
  );

  // write decode
  wire wr_ctrl = wr && addr == hdc_pkg::ADDR_CTRL;
  wire wr_man = wr && addr == hdc_pkg::ADDR_MAN_LO;
  wire wr_tlo = wr && addr == hdc_pkg::ADDR_TRIP_LO;
  wire wr_thi = wr && addr == hdc_pkg::ADDR_TRIP_HI;
  wire wr_sw = wr && addr == hdc_pkg::ADDR_SWITCH;
  wire wr_stat = wr && addr == hdc_pkg::ADDR_STATUS;
  wire wr_mask = wr && addr == hdc_pkg::ADDR_MASK;

  // detector setup straight from the control byte
  assign signal_absence_timeout = ctrl.timeout;
  assign signal_absence_enable = ctrl.absence_en;

  // manual code assembled from two registers
  wire [9:0] man_code = {ctrl.man_hi, man_lo};

  // tracking rate divider and step condition
  wire track_tick = div_cnt == DIV_LAST;
  wire hold = state == hdc_pkg::HDC_HOLDOVER;
  wire track_step = ctrl.track_en && lock_s && !hold && track_tick;
  wire step_up = above_s && trk != hdc_pkg::CODE_MAX;
  wire step_dn = !above_s && trk != 10'h000;
  assign next_trk = !track_step ? trk : step_up ? trk + 10'h001 : step_dn ? trk - 10'h001 : trk;

  // trip compares on the tracked code
  wire low_trip = sw.vtune_en && code_top(trk) <= trip_lo;
  wire high_trip = sw.vtune_en && code_top(trk) >= 6'(hdc_pkg::TRIP_TOP - trip_hi);
  wire trip = low_trip || high_trip;

  // input loss and lock loss events
  wire abs_on = ctrl.absence_en && abs_s;
  wire lock_fall = lock_d && !lock_s;
  wire switch_evt = sw.freeze_en && lock_fall;
  wire abs_rise = ctrl.absence_en && abs_s && !abs_d;

  // entry causes, levels that keep holdover, and exit qualifier
  wire enter = ctrl.force_hold || trip || abs_on || switch_evt;
  wire keep = ctrl.force_hold || trip || abs_on || switch_evt;
  wire exit_ok = sw.exit_on_lock ? lock_s : !abs_s;
  wire enter_now = !hold && enter;
  wire exit_now = hold && !keep && exit_ok;

  // holdover state
  always_comb begin
    next_state = state;
    unique case (state)
      hdc_pkg::HDC_NORMAL: begin
        if (enter) begin
          next_state = hdc_pkg::HDC_HOLDOVER;
        end
      end
      hdc_pkg::HDC_HOLDOVER: begin
        if (!keep && exit_ok) begin
          next_state = hdc_pkg::HDC_NORMAL;
        end
      end
    endcase
  end

  // dac source: manual or tracked in holdover, tracked otherwise
  assign next_dac = (hold && ctrl.man_sel) ? man_code : trk;

  // event vector and interrupt
  wire [4:0] evt = {enter_now && trip, abs_rise, switch_evt, exit_now, enter_now};
  wire [4:0] clr = wr_stat ? wdata[4:0] : 5'h00;
  assign irq = |(status & mask);
  assign holdover_active = hold;

  // read select; reserved bits come back zero
  assign next_rdata =
    addr == hdc_pkg::ADDR_CTRL ? ctrl :
    addr == hdc_pkg::ADDR_MAN_LO ? man_lo :
    addr == hdc_pkg::ADDR_TRIP_LO ? {2'h0, trip_lo} :
    addr == hdc_pkg::ADDR_TRIP_HI ? {2'h0, trip_hi} :
    addr == hdc_pkg::ADDR_SWITCH ? {2'h0, sw.exit_on_lock, sw.freeze_en, 1'h0, sw.vtune_en, 2'h0} :
    addr == hdc_pkg::ADDR_STATUS ? {3'h0, status} :
    addr == hdc_pkg::ADDR_MASK ? {3'h0, mask} :
    addr == hdc_pkg::ADDR_STATE ? {4'h0, hold, above_s, lock_s, abs_s} :
    addr == hdc_pkg::ADDR_CODE_HI ? {6'h00, trk[9:8]} :
    addr == hdc_pkg::ADDR_CODE_LO ? trk[7:0] :
    8'h00;

  // software registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl <= hdc_pkg::CTRL_RESET;
      man_lo <= 8'h00;
      trip_lo <= 6'h00;
      trip_hi <= 6'h00;
      sw <= '0;
      mask <= 5'h00;
    end else begin
      if (wr_ctrl) ctrl <= wdata;
      if (wr_man) man_lo <= wdata;
      if (wr_tlo) trip_lo <= wdata[5:0];
      if (wr_thi) trip_hi <= wdata[5:0];
      if (wr_sw) sw <= {wdata[hdc_pkg::SW_EXIT_BIT], wdata[hdc_pkg::SW_FREEZE_BIT], wdata[hdc_pkg::SW_VTUNE_BIT]};
      if (wr_mask) mask <= wdata[4:0];
    end
  end

  // sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status <= 5'h00;
    end else begin
      status <= (status & ~clr) | evt;
    end
  end

  // tracking, state, dac and edge history
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      trk <= hdc_pkg::TRACK_START;
      div_cnt <= 16'h0000;
      state <= hdc_pkg::HDC_NORMAL;
      dac_code <= hdc_pkg::TRACK_START;
      lock_d <= 1'b0;
      abs_d <= 1'b0;
      clock_switch_event <= 1'b0;
    end else begin
      trk <= next_trk;
      div_cnt <= track_tick ? 16'h0000 : div_cnt + 16'h0001;
      state <= next_state;
      dac_code <= next_dac;
      lock_d <= lock_s;
      abs_d <= abs_s;
      clock_switch_event <= switch_evt;
    end
  end

  // read data only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_lock_fall;
    sw.freeze_en ##0 lock_d && !lock_s;
  endsequence

  sequence s_step_up;
    track_step && above_s && trk != hdc_pkg::CODE_MAX;
  endsequence

  sequence s_step_dn;
    track_step && !above_s && trk != 10'h000;
  endsequence

  a_timeout_field: assert property (wr_ctrl |=> signal_absence_timeout == $past(wdata[7:6]))
    else $error("timeout field not taken from write");
  a_absence_enable: assert property (wr_ctrl |=> signal_absence_enable == $past(wdata[5]))
    else $error("absence enable not taken from write");
  a_track_lock_gate: assert property ((!lock_s || !ctrl.track_en) |=> trk == $past(trk))
    else $error("tracked code moved without lock or enable");
  a_track_start: assert property ($rose(rstn) |-> trk == 10'h200 && dac_code == 10'h200)
    else $error("tracked code did not start at 512");
  a_track_step_up: assert property (s_step_up |=> trk == $past(trk) + 10'h001)
    else $error("tracking step up missing");
  a_force_hold: assert property (ctrl.force_hold |=> holdover_active)
    else $error("force did not hold");
  a_dac_manual: assert property (hold && ctrl.man_sel |=> dac_code == $past(man_code))
    else $error("manual code not on dac");
  a_dac_tracked: assert property (hold && !ctrl.man_sel |=> dac_code == $past(trk))
    else $error("tracked code not on dac");
  a_ctrl_reset: assert property ($rose(rstn) |-> ctrl.man_sel && ctrl.man_hi == 2'h2)
    else $error("control reset value wrong");
  a_low_trip: assert property (sw.vtune_en && trk[9:4] <= trip_lo |=> holdover_active)
    else $error("low trip missed");
  a_high_trip: assert property (sw.vtune_en && trk[9:4] + trip_hi >= 7'd63 |=> holdover_active)
    else $error("high trip missed");
  a_exit_lock: assert property (hold && sw.exit_on_lock && !lock_s |=> holdover_active)
    else $error("left holdover without lock");
  a_lock_fall: assert property (s_lock_fall |=> clock_switch_event && holdover_active)
    else $error("lock loss event missing");
  a_no_freeze: assert property (!sw.freeze_en |=> !clock_switch_event)
    else $error("switch event while disabled");
  a_trip_reserved: assert property (rd && addr == hdc_pkg::ADDR_TRIP_LO |=> rdata[7:6] == 2'h0)
    else $error("reserved bits not zero");
  a_status_sticky: assert property (evt != 5'h00 |=> (status & $past(evt)) == $past(evt))
    else $error("event lost from status");

  // register port readback and reserved bits
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero without strobe");
  a_read_ctrl: assert property (rd && addr == hdc_pkg::ADDR_CTRL |=> rdata == $past(ctrl))
    else $error("control readback wrong");
  a_read_man: assert property (rd && addr == hdc_pkg::ADDR_MAN_LO |=> rdata == $past(man_lo))
    else $error("manual low readback wrong");
  a_switch_reserved: assert property (rd && addr == hdc_pkg::ADDR_SWITCH |=> (rdata & 8'hcb) == 8'h00)
    else $error("switch reserved bits not zero");
  a_status_reserved: assert property (rd && addr == hdc_pkg::ADDR_STATUS |=> rdata[7:5] == 3'h0)
    else $error("status reserved bits not zero");
  a_unmapped_read: assert property (rd && addr < hdc_pkg::ADDR_CTRL |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_code_read_hi: assert property (rd && addr == hdc_pkg::ADDR_CODE_HI |=> rdata == {6'h00, $past(trk[9:8])})
    else $error("tracked code high readback wrong");
  a_code_read_lo: assert property (rd && addr == hdc_pkg::ADDR_CODE_LO |=> rdata == $past(trk[7:0]))
    else $error("tracked code low readback wrong");

  // register writes
  a_man_write: assert property (wr_man |=> man_lo == $past(wdata))
    else $error("manual low not written");
  a_man_hi_write: assert property (wr_ctrl |=> ctrl.man_hi == $past(wdata[1:0]))
    else $error("manual high bits not written");
  a_man_sel_write: assert property (wr_ctrl |=> ctrl.man_sel == $past(wdata[2]))
    else $error("manual select not written");
  a_force_write: assert property (wr_ctrl |=> ctrl.force_hold == $past(wdata[3]))
    else $error("force bit not written");
  a_track_en_write: assert property (wr_ctrl |=> ctrl.track_en == $past(wdata[4]))
    else $error("tracking enable not written");
  a_trip_write: assert property (wr_tlo |=> trip_lo == $past(wdata[5:0]))
    else $error("low trip not written");
  a_trip_hi_write: assert property (wr_thi |=> trip_hi == $past(wdata[5:0]))
    else $error("high trip not written");
  a_mask_write: assert property (wr_mask |=> mask == $past(wdata[4:0]))
    else $error("mask not written");
  a_timeout_stable: assert property (!wr_ctrl |=> $stable(signal_absence_timeout))
    else $error("timeout field moved without write");

  // tracking and dac source
  a_step_down: assert property (s_step_dn |=> trk == $past(trk) - 10'h001)
    else $error("tracking step down missing");
  a_hold_freeze: assert property (hold |=> trk == $past(trk))
    else $error("tracked code moved in holdover");
  a_dac_follow: assert property (!hold |=> dac_code == $past(trk))
    else $error("dac not following tracked code");

  // holdover entry and exit
  a_absence_hold: assert property (ctrl.absence_en && abs_s |=> holdover_active)
    else $error("input loss did not hold");
  a_no_cause: assert property (!hold && !ctrl.force_hold && !trip && !abs_on && !switch_evt
    |=> !holdover_active)
    else $error("holdover without cause");
  a_exit_absence: assert property (hold && !sw.exit_on_lock && abs_s |=> holdover_active)
    else $error("left holdover with input still lost");
  a_exit_mode0: assert property (hold && !keep && !sw.exit_on_lock && !abs_s |=> !holdover_active)
    else $error("no exit on input activity");
  a_exit_mode1: assert property (hold && !keep && sw.exit_on_lock && lock_s |=> !holdover_active)
    else $error("no exit on lock");
  a_switch_pulse: assert property (clock_switch_event |=> !clock_switch_event)
    else $error("switch event longer than one cycle");

  // status flags
  a_enter_flag: assert property (enter_now |=> status[hdc_pkg::EVT_ENTER])
    else $error("entry flag not set");
  a_trip_flag: assert property (enter_now && trip |=> status[hdc_pkg::EVT_TRIP])
    else $error("trip flag not set");
  a_status_clear: assert property (wr_stat && wdata[0] && !evt[0] |=> !status[0])
    else $error("status bit not cleared");

endmodule
`default_nettype wire

// file: hdc_pkg.sv
/*
  holdover dac control: register offsets, field layouts, reset values,
  event bit positions and the state type shared by the design files.
  assumes a byte-wide register port with a 9-bit address.
*/
`default_nettype none
package hdc_pkg;

  // register port geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [8:0] ADDR_CTRL = 9'h14b;
  localparam logic [8:0] ADDR_MAN_LO = 9'h14c;
  localparam logic [8:0] ADDR_TRIP_LO = 9'h14d;
  localparam logic [8:0] ADDR_TRIP_HI = 9'h14e;
  localparam logic [8:0] ADDR_SWITCH = 9'h150;
  localparam logic [8:0] ADDR_STATUS = 9'h151;
  localparam logic [8:0] ADDR_MASK = 9'h152;
  localparam logic [8:0] ADDR_STATE = 9'h153;
  localparam logic [8:0] ADDR_CODE_HI = 9'h154;
  localparam logic [8:0] ADDR_CODE_LO = 9'h155;

  // reset values and code limits
  localparam logic [7:0] CTRL_RESET = 8'h06;
  localparam logic [9:0] TRACK_START = 10'h200;
  localparam logic [9:0] CODE_MAX = 10'h3ff;
  localparam logic [5:0] TRIP_TOP = 6'h3f;

  // switch register field positions
  localparam int SW_EXIT_BIT = 5;
  localparam int SW_FREEZE_BIT = 4;
  localparam int SW_VTUNE_BIT = 2;

  // event bit positions in status and mask
  localparam int EVT_W = 5;
  localparam int EVT_ENTER = 0;
  localparam int EVT_EXIT = 1;
  localparam int EVT_SWITCH = 2;
  localparam int EVT_ABSENCE = 3;
  localparam int EVT_TRIP = 4;

  // main control register, one byte
  typedef struct packed {
    logic [1:0] timeout;
    logic absence_en;
    logic track_en;
    logic force_hold;
    logic man_sel;
    logic [1:0] man_hi;
  } hdc_ctrl_t;

  // switch control fields
  typedef struct packed {
    logic exit_on_lock;
    logic freeze_en;
    logic vtune_en;
  } hdc_switch_t;

  typedef enum logic {HDC_NORMAL, HDC_HOLDOVER} hdc_state_t;

endpackage
`default_nettype wire

// file: hdc_sync.sv
/*
  three-stage synchroniser for pin inputs; the output level only changes
  once the second and third stages agree.
  assumes sys_clk and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module hdc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // asynchronous inputs and filtered levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // take a new level only where stages two and three agree
  assign next_level = (stage2 & stage3) | (level & (stage2 | stage3));

  // shift chain; stage1 feeds only stage2
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

endmodule
`default_nettype wire

// file: test_hdc_holdover.sv
/*
  self-checking bench for hdc_holdover: register port, dac source, holdover
  entry and exit, trip levels, lock loss and interrupt status.
  assumes the design files are compiled first; TRACK_DIV is shortened to 4.
*/
`timescale 1ns/100ps
`default_nettype none
module test_hdc_holdover;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic lock = 1'b0;
  logic absent = 1'b0;
  logic above = 1'b0;
  logic [7:0] rdata;
  logic [1:0] timeout;
  logic abs_en;
  logic [9:0] dac_code;
  logic hold;
  logic sw_evt;
  logic irq;
  int num_errors = 0;
  int checked = 0;

  hdc_holdover #(.TRACK_DIV(4)) hdc_holdover_i (
    .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .first_loop_lock(lock), .signal_absence(absent), .tune_above_dac(above),
    .signal_absence_timeout(timeout), .signal_absence_enable(abs_en), .dac_code(dac_code),
    .holdover_active(hold), .clock_switch_event(sw_evt), .irq(irq));

  // clock at 200 MHz
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // one-cycle write strobe
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // read data stand in the cycle after the strobe
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  task automatic rd_code(output logic [9:0] c);
    @(posedge sys_clk);
    addr <= hdc_pkg::ADDR_CODE_HI;
    rd <= 1'b1;
    @(posedge sys_clk);
    addr <= hdc_pkg::ADDR_CODE_LO;
    #1;
    c[9:8] = rdata[1:0];
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    c[7:0] = rdata;
  endtask

  // bounded wait for the holdover level
  task automatic wait_hold(input logic v);
    for (int i = 0; i < 30 && hold !== v; i++) idle(1);
    chk({15'h0000, hold}, {15'h0000, v});
  endtask

  task automatic t_reset();
    chk({6'h00, dac_code}, 16'h0200);
    chk({12'h000, timeout, abs_en, hold}, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    rd_chk(hdc_pkg::ADDR_CTRL, 8'h06);
    rd_chk(hdc_pkg::ADDR_MAN_LO, 8'h00);
    rd_chk(hdc_pkg::ADDR_TRIP_LO, 8'h00);
    rd_chk(hdc_pkg::ADDR_CODE_HI, 8'h02);
    rd_chk(hdc_pkg::ADDR_CODE_LO, 8'h00);
    rd_chk(9'h100, 8'h00);
  endtask

  task automatic t_config();
    for (int c = 0; c < 4; c++) begin
      wr_reg(hdc_pkg::ADDR_CTRL, 8'h26 | 8'(c << 6));
      idle(1);
      chk({14'h0000, timeout}, 16'(c));
      chk({15'h0000, abs_en}, 16'h0001);
    end
    wr_reg(hdc_pkg::ADDR_CTRL, 8'h06);
    idle(1);
    chk({15'h0000, abs_en}, 16'h0000);
    wr_reg(hdc_pkg::ADDR_TRIP_LO, 8'hff);
    rd_chk(hdc_pkg::ADDR_TRIP_LO, 8'h3f);
    wr_reg(hdc_pkg::ADDR_TRIP_LO, 8'h00);
    wr_reg(9'h100, 8'hff);
    rd_chk(hdc_pkg::ADDR_CTRL, 8'h06);
  endtask

  task automatic t_force();
    wr_reg(hdc_pkg::ADDR_MAN_LO, 8'ha5);
    wr_reg(hdc_pkg::ADDR_MASK, 8'h01);
    wr_reg(hdc_pkg::ADDR_CTRL, 8'h0f);
    wait_hold(1'b1);
    idle(2);
    chk({6'h00, dac_code}, 16'h03a5);
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(hdc_pkg::ADDR_MASK, 8'h00);
    idle(1);
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(hdc_pkg::ADDR_MASK, 8'h01);
    idle(1);
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(hdc_pkg::ADDR_STATUS, 8'h01);
    idle(1);
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(hdc_pkg::ADDR_CTRL, 8'h0b);
    idle(2);
    chk({6'h00, dac_code}, 16'h0200);
    wr_reg(hdc_pkg::ADDR_CTRL, 8'h07);
    wait_hold(1'b0);
  endtask

  // tracked code 512 has top six bits 32; high trip needs 32 >= 63 - n
  task automatic t_trip();
    wr_reg(hdc_pkg::ADDR_TRIP_LO, 8'h20);
    wr_reg(hdc_pkg::ADDR_SWITCH, 8'h04);
    wait_hold(1'b1);
    wr_reg(hdc_pkg::ADDR_TRIP_LO, 8'h1f);
    wait_hold(1'b0);
    wr_reg(hdc_pkg::ADDR_TRIP_HI, 8'h1e);
    idle(8);
    chk({15'h0000, hold}, 16'h0000);
    wr_reg(hdc_pkg::ADDR_TRIP_HI, 8'h1f);
    wait_hold(1'b1);
    wr_reg(hdc_pkg::ADDR_TRIP_HI, 8'h00);
    wait_hold(1'b0);
  endtask

  task automatic t_lock();
    int n;
    for (int en = 1; en >= 0; en--) begin
      wr_reg(hdc_pkg::ADDR_SWITCH, en ? 8'h30 : 8'h20);
      lock <= 1'b1;
      wait_hold(1'b0);
      idle(8);
      @(posedge sys_clk);
      lock <= 1'b0;
      n = 0;
      repeat (12) begin
        idle(1);
        n += int'(sw_evt === 1'b1);
      end
      chk(16'(n), 16'(en));
      chk({15'h0000, hold}, 16'(en));
    end
    wr_reg(hdc_pkg::ADDR_SWITCH, 8'h00);
    lock <= 1'b1;
    wr_reg(hdc_pkg::ADDR_CTRL, 8'h26);
    absent <= 1'b1;
    wait_hold(1'b1);
    @(posedge sys_clk);
    absent <= 1'b0;
    wait_hold(1'b0);
  endtask

  task automatic t_track();
    logic [9:0] c1;
    logic [9:0] c2;
    wr_reg(hdc_pkg::ADDR_CTRL, 8'h10);
    above <= 1'b1;
    idle(40);
    @(posedge sys_clk);
    lock <= 1'b0;
    idle(8);
    rd_code(c1);
    chk(16'(c1 > 10'h200 && c1 <= 10'h21c), 16'h0001);
    idle(20);
    rd_code(c2);
    chk({6'h00, c2}, {6'h00, c1});
    chk({6'h00, dac_code}, {6'h00, c1});
    @(posedge sys_clk);
    above <= 1'b0;
    lock <= 1'b1;
    wr_reg(hdc_pkg::ADDR_CTRL, 8'h18);
    wait_hold(1'b1);
    rd_code(c1);
    idle(40);
    rd_code(c2);
    chk({6'h00, c2}, {6'h00, c1});
    chk({6'h00, dac_code}, {6'h00, c1});
  endtask

  // watchdog well beyond the expected run
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end

  // reset for four cycles, then the scenarios
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    idle(1);
    t_reset();
    t_config();
    t_force();
    t_trip();
    t_lock();
    t_track();
    stop_test();
  end
endmodule
`default_nettype wire
